// file: src/lsal_consts.svh
/*
 status and alert logic of a light sensor: reset values, range codes and fault counts.
 assumes it is included by its bare name from the modules.
*/
`ifndef LSAL_CONSTS_SVH
`define LSAL_CONSTS_SVH

// configuration register after reset: auto range, long conversion, shutdown, latched
`define LSAL_CFG_RESET 16'hc810
// range code that selects automatic range stepping
`define LSAL_AUTO_RANGE 4'hc
// lowest and highest real range codes
`define LSAL_LOW_RANGE 4'h0
`define LSAL_TOP_RANGE 4'hb
// exponent reported while masking is active
`define LSAL_MASKED_EXP 4'h0
// consecutive fault counts for each fault_repeat_count code
`define LSAL_FAULT_N1 4'h1
`define LSAL_FAULT_N2 4'h2
`define LSAL_FAULT_N4 4'h4
`define LSAL_FAULT_N8 4'h8
// field layout of a result or limit word
`define LSAL_EXP_HI 15
`define LSAL_EXP_LO 12
`define LSAL_MANT_HI 11
`define LSAL_MANT_LO 0
// limit slots in the compare loop
`define LSAL_SLOT_LOW 0
`define LSAL_SLOT_HIGH 1
`define LSAL_SLOTS 2

`endif

// file: src/lsal_fault_count.sv
/*
 consecutive fault counter for one limit.
 assumes sample pulses once per finished measurement.
*/
`include "lsal_consts.svh"
`default_nettype none

module lsal_fault_count
	import lsal_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic sample,
	input wire logic violate,
	input wire logic [3:0] need,
	output logic qualified
);

	lsal_fault_state_t s;
	lsal_fault_state_t next_s;
	logic [3:0] bumped;

	always_comb begin
		next_s = s;
		// saturates at the needed count so a long run never wraps
		bumped = (s.count < need) ? 4'(s.count + 4'h1) : s.count;
		qualified = sample && violate && (bumped >= need);
		if (sample) begin
			next_s.count = violate ? bumped : 4'h0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

`default_nettype wire

// file: src/lsal_pkg.sv
/*
 types of the light sensor status and alert logic.
 assumes lsal_consts.svh sits on the include path.
*/
`default_nettype none

package lsal_pkg;

	typedef enum logic [1:0] {
		LSAL_MODE_OFF = 2'b00,
		LSAL_MODE_ONE = 2'b01,
		LSAL_MODE_RUN_A = 2'b10,
		LSAL_MODE_RUN_B = 2'b11
	} lsal_mode_t;

	typedef enum logic [1:0] {
		LSAL_SEQ_IDLE = 2'b00,
		LSAL_SEQ_BUSY = 2'b01
	} lsal_seq_t;

	// configuration and status register, bit 15 first
	typedef struct packed {
		logic [3:0] range_select;
		logic conv_long;
		lsal_mode_t mode;
		logic overflow_flag;
		logic conversion_done_flag;
		logic above_limit_flag;
		logic below_threshold_mark;
		logic hold_select;
		logic alert_level_select;
		logic exponent_masking;
		logic [1:0] fault_repeat_count;
	} lsal_cfg_t;

	// register access from the serial bus engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} lsal_host_t;

	// request to the converter core
	typedef struct packed {
		logic start;
		logic abort;
		logic [3:0] range;
		logic long_time;
	} lsal_conv_req_t;

	// answer of the converter core
	typedef struct packed {
		logic done;
		logic overload;
		logic [11:0] mantissa;
	} lsal_conv_rsp_t;

	typedef struct packed {
		lsal_seq_t seq;
		lsal_cfg_t cfg;
		logic [3:0] cur_range;
		logic ovl_seen;
		logic [15:0] result;
		logic [15:0] rdata;
		lsal_conv_req_t req;
	} lsal_state_t;

	typedef struct packed {
		logic [3:0] count;
	} lsal_fault_state_t;

endpackage

`default_nettype wire

// file: src/lsal_power_cmp.sv
/*
 compares a measurement against a limit as linear power, mantissa shifted by exponent.
 assumes both words share the result layout: exponent on top, mantissa below.
*/
`include "lsal_consts.svh"
`default_nettype none

module lsal_power_cmp
	import lsal_pkg::*;
(
	input wire logic [15:0] meas,
	input wire logic [15:0] limit,
	output logic above,
	output logic below
);

	// wide enough for the reserved exponents too, so nothing is lost
	logic [26:0] meas_lin;
	logic [26:0] limit_lin;

	always_comb begin
		meas_lin = {15'h0, meas[`LSAL_MANT_HI:`LSAL_MANT_LO]} << meas[`LSAL_EXP_HI:`LSAL_EXP_LO];
		limit_lin = {15'h0, limit[`LSAL_MANT_HI:`LSAL_MANT_LO]} << limit[`LSAL_EXP_HI:`LSAL_EXP_LO];
		above = meas_lin > limit_lin;
		below = meas_lin < limit_lin;
	end

endmodule

`default_nettype wire

// file: src/lsal_status_alert.sv
/*
 status flags, auto ranging and alert pin of a light sensor configuration register.
 assumes a serial bus engine that gives one-cycle read and write strobes, a converter
 core that reports overload during integration and pulses done with its mantissa,
 and limit words held elsewhere. the alert pin is open drain with an external pull-up.
*/
// What this block does
// - overflow flag is 1 when the conversion overloads, otherwise 0
// - overflow flag is recomputed at the end of every measurement
// - manual range: overflow may show though result is below full scale
// - auto range: overflow only when input exceeds the top range
// - overload below top range: abort, step range up, restart, then update flag
// - done flag set per conversion; cleared on read or non-shutdown write
// - above-limit flag set after enough consecutive results over high limit
// - below-limit flag set after enough consecutive results under low limit
// - the four status bits are read-only; written values for them are ignored
// - hold select 0: flags and alert track the comparison, no clearing
// - hold select 1 (reset): flags and alert stay until the host reads
// - alert level select 0 (reset): pin pulled low on an event
// - alert level select 1: pin released on an event, pull-up makes it high
// - masking on with manual range: result exponent reads as zero
// - masking changes only the reported result, not the limit compare
// - fault repeat 00/01/10/11 needs one, two, four or eight faults
// - mode 00 shutdown, 01 single then back to 00, 10 or 11 continuous
// - entering shutdown leaves done flag, limit flags and alert unchanged
// - range code 1100b selects auto ranging; chosen range goes to exponent
`include "lsal_consts.svh"
`default_nettype none

module lsal_status_alert
	import lsal_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire lsal_host_t host,
	output logic [15:0] cfg_rdata,
	input wire logic [15:0] low_limit,
	input wire logic [15:0] high_limit,
	output lsal_conv_req_t conv_req,
	input wire lsal_conv_rsp_t conv_rsp,
	output logic [15:0] result_value,
	input wire logic alert_in,
	output logic alert_out,
	output logic alert_oe
);

	lsal_state_t s;
	lsal_state_t next_s;
	lsal_cfg_t wcfg;
	logic auto_mode;
	logic step_up;
	logic fire;
	logic event_on;
	logic [3:0] need;
	logic [3:0] report_exp;
	logic [15:0] meas_word;
	logic [`LSAL_SLOTS-1:0][15:0] limits;
	logic [`LSAL_SLOTS-1:0] above;
	logic [`LSAL_SLOTS-1:0] below;
	logic [`LSAL_SLOTS-1:0] violate;
	logic [`LSAL_SLOTS-1:0] qualified;

	assign wcfg = lsal_cfg_t'(host.wdata);
	assign auto_mode = s.cfg.range_select == `LSAL_AUTO_RANGE;
	assign limits[`LSAL_SLOT_LOW] = low_limit;
	assign limits[`LSAL_SLOT_HIGH] = high_limit;

	// unmasked word of the running measurement feeds the compare
	assign meas_word = {s.cur_range, conv_rsp.mantissa};

	// an overload only restarts while there is a higher range to go to
	assign step_up = auto_mode && conv_rsp.overload && (s.cur_range < `LSAL_TOP_RANGE);

	always_comb begin
		case (s.cfg.fault_repeat_count)
			2'b00: begin
				need = `LSAL_FAULT_N1;
			end
			2'b01: begin
				need = `LSAL_FAULT_N2;
			end
			2'b10: begin
				need = `LSAL_FAULT_N4;
			end
			default: begin
				need = `LSAL_FAULT_N8;
			end
		endcase
	end

	genvar i;
	generate
		for (i = 0; i < `LSAL_SLOTS; i = i + 1) begin : g_limit
			lsal_power_cmp u_cmp (
				.meas(meas_word),
				.limit(limits[i]),
				.above(above[i]),
				.below(below[i])
			);

			if (i == `LSAL_SLOT_HIGH) begin : g_high
				assign violate[i] = above[i];
			end else begin : g_low
				assign violate[i] = below[i];
			end

			lsal_fault_count u_fault (
				.clock(clock),
				.rst(rst),
				.sample(fire),
				.violate(violate[i]),
				.need(need),
				.qualified(qualified[i])
			);
		end
	endgenerate

	always_comb begin
		// exponent masking only when the range is set by hand
		if (s.cfg.exponent_masking && (s.cfg.range_select < `LSAL_AUTO_RANGE)) begin
			report_exp = `LSAL_MASKED_EXP;
		end else begin
			report_exp = s.cur_range;
		end
	end

	always_comb begin
		next_s = s;
		fire = 1'b0;
		next_s.req.start = 1'b0;
		next_s.req.abort = 1'b0;

		// host access comes first so that hardware events below win over it
		if (host.rd) begin
			next_s.rdata = s.cfg;
			next_s.cfg.conversion_done_flag = 1'b0;
			if (s.cfg.hold_select) begin
				next_s.cfg.above_limit_flag = 1'b0;
				next_s.cfg.below_threshold_mark = 1'b0;
			end
		end
		if (host.wr) begin
			// status positions of the written word are dropped
			next_s.cfg.range_select = wcfg.range_select;
			next_s.cfg.conv_long = wcfg.conv_long;
			next_s.cfg.mode = wcfg.mode;
			next_s.cfg.hold_select = wcfg.hold_select;
			next_s.cfg.alert_level_select = wcfg.alert_level_select;
			next_s.cfg.exponent_masking = wcfg.exponent_masking;
			next_s.cfg.fault_repeat_count = wcfg.fault_repeat_count;
			if (wcfg.mode != LSAL_MODE_OFF) begin
				next_s.cfg.conversion_done_flag = 1'b0;
			end
		end

		case (s.seq)
			LSAL_SEQ_IDLE: begin
				if (s.cfg.mode != LSAL_MODE_OFF) begin
					next_s.seq = LSAL_SEQ_BUSY;
					next_s.cur_range = auto_mode ? `LSAL_LOW_RANGE : s.cfg.range_select;
					next_s.ovl_seen = 1'b0;
					next_s.req.start = 1'b1;
				end
			end
			LSAL_SEQ_BUSY: begin
				if (s.cfg.mode == LSAL_MODE_OFF) begin
					// shutdown stops the converter and touches no flag
					next_s.seq = LSAL_SEQ_IDLE;
					next_s.req.abort = 1'b1;
				end else if (step_up) begin
					next_s.cur_range = 4'(s.cur_range + 4'h1);
					next_s.ovl_seen = 1'b0;
					next_s.req.abort = 1'b1;
					next_s.req.start = 1'b1;
				end else if (conv_rsp.done) begin
					fire = 1'b1;
					next_s.ovl_seen = 1'b0;
					// a manual range keeps a transient overload even if the result fits
					next_s.cfg.overflow_flag = s.ovl_seen | conv_rsp.overload;
					next_s.cfg.conversion_done_flag = 1'b1;
					next_s.result = {report_exp, conv_rsp.mantissa};
					if (s.cfg.mode == LSAL_MODE_ONE) begin
						next_s.cfg.mode = LSAL_MODE_OFF;
						next_s.seq = LSAL_SEQ_IDLE;
					end else begin
						next_s.cur_range = auto_mode ? `LSAL_LOW_RANGE : s.cfg.range_select;
						next_s.req.start = 1'b1;
					end
				end else if (conv_rsp.overload) begin
					next_s.ovl_seen = 1'b1;
				end
			end
			default: begin
				next_s.seq = LSAL_SEQ_IDLE;
			end
		endcase

		// the converter always sees the range that the request carries
		next_s.req.range = next_s.cur_range;
		next_s.req.long_time = s.cfg.conv_long;

		if (fire) begin
			if (s.cfg.hold_select) begin
				// a set in the cycle of a clearing read still wins
				if (qualified[`LSAL_SLOT_HIGH]) begin
					next_s.cfg.above_limit_flag = 1'b1;
				end
				if (qualified[`LSAL_SLOT_LOW]) begin
					next_s.cfg.below_threshold_mark = 1'b1;
				end
			end else begin
				next_s.cfg.above_limit_flag = qualified[`LSAL_SLOT_HIGH];
				next_s.cfg.below_threshold_mark = qualified[`LSAL_SLOT_LOW];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s.seq <= LSAL_SEQ_IDLE;
			s.cfg <= lsal_cfg_t'(`LSAL_CFG_RESET);
			s.cur_range <= `LSAL_LOW_RANGE;
			s.ovl_seen <= 1'b0;
			s.result <= 16'h0000;
			s.rdata <= 16'h0000;
			s.req <= '0;
		end else begin
			s <= next_s;
		end
	end

	// the pin follows the flags, so both hold styles carry over to it
	assign event_on = s.cfg.above_limit_flag | s.cfg.below_threshold_mark;

	// open drain: the device only ever pulls low; the pin level is not read back
	assign alert_out = 1'b0;
	assign alert_oe = s.cfg.alert_level_select ? ~event_on : event_on;

	assign cfg_rdata = s.rdata;
	assign result_value = s.result;
	assign conv_req = s.req;

endmodule

`default_nettype wire

// file: test/lsal_assertions.sv
/*
 port checker of the light sensor status and alert logic.
 assumes it is bound to lsal_status_alert and sees only its ports.
*/
`default_nettype none

module lsal_assertions
	import lsal_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire lsal_host_t host,
	input wire logic [15:0] cfg_rdata,
	input wire lsal_conv_req_t conv_req,
	input wire lsal_conv_rsp_t conv_rsp,
	input wire logic [15:0] result_value,
	input wire logic alert_out,
	input wire logic alert_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// a read with no conversion ending beside it, then a second read
	sequence s_clean_rd;
		host.rd && !conv_rsp.done;
	endsequence
	sequence s_two_rd;
		s_clean_rd ##1 host.rd;
	endsequence
	a_rd_clears_done: assert property (s_two_rd |=> !cfg_rdata[7])
		else $error("done flag survived a read");
	a_pin_open_drain: assert property (alert_out == 1'b0)
		else $error("alert pin driven high");
	a_range_step_up: assert property (conv_req.start && conv_req.abort |->
		conv_req.range == $past(conv_req.range) + 4'h1)
		else $error("restart range not one above");
	a_range_legal: assert property (conv_req.start |-> conv_req.range <= 4'hb)
		else $error("start with reserved range");
	a_start_single: assert property (conv_req.start |=> !conv_req.start)
		else $error("start held two cycles");
	a_result_source: assert property ($changed(result_value) |->
		$past(conv_rsp.done) && result_value[11:0] == $past(conv_rsp.mantissa))
		else $error("result changed without a done");
	a_rdata_hold: assert property (!$past(host.rd) |-> $stable(cfg_rdata))
		else $error("read data changed without a read");
	a_alert_cause: assert property ($changed(alert_oe) |->
		$past(conv_rsp.done || host.rd || host.wr))
		else $error("alert moved without a cause");
endmodule

`default_nettype wire

// file: test/lsal_conv_model.sv
/*
 behavioural converter core that answers start with done after wait_n + 1 cycles.
 assumes overload is reported with done while the range is below thr.
*/
`default_nettype none

module lsal_conv_model
	import lsal_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire lsal_conv_req_t conv_req,
	output lsal_conv_rsp_t conv_rsp,
	input wire logic [11:0] mant,
	input wire logic [3:0] thr,
	input wire logic [3:0] wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy;
	logic [3:0] cnt;
	logic [3:0] rng;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			rng <= 4'h0;
			conv_rsp <= '0;
		end else begin
			conv_rsp.done <= 1'b0;
			conv_rsp.overload <= 1'b0;
			// mantissa is only valid with done, so it keeps moving
			conv_rsp.mantissa <= ~conv_rsp.mantissa;
			if (conv_req.start) begin
				busy <= 1'b1;
				cnt <= wait_n;
				rng <= conv_req.range;
			end else if (conv_req.abort) begin
				busy <= 1'b0;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				conv_rsp.done <= 1'b1;
				conv_rsp.overload <= rng < thr;
				conv_rsp.mantissa <= mant;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// file: test/lsal_status_alert_bench.sv
/*
 self-checking bench of lsal_status_alert with a converter model.
 assumes an external pull-up on the alert pin.
*/
`default_nettype none

module lsal_status_alert_bench
	import lsal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	lsal_host_t host = '0;
	logic [15:0] low_limit = '0, high_limit = '0, cfg_rdata, result_value, rd_v, cf, ex;
	lsal_conv_req_t conv_req;
	lsal_conv_rsp_t conv_rsp;
	logic [11:0] mant = '0;
	logic [3:0] thr = '0, wait_n = 4'h2;
	logic alert_out, alert_oe, ev, lo;
	logic [15:0] tab [3] = '{16'hc343, 16'hcfcb, 16'h2f12};
	int num_errors = 0, checks_done = 0, seed = 32'h4d4ec41b;
	wire alert_pin = alert_oe ? alert_out : 1'b1;

	lsal_status_alert u_dut (.clock(clock), .rst(rst), .host(host), .cfg_rdata(cfg_rdata),
		.low_limit(low_limit), .high_limit(high_limit), .conv_req(conv_req),
		.conv_rsp(conv_rsp), .result_value(result_value), .alert_in(alert_pin),
		.alert_out(alert_out), .alert_oe(alert_oe));
	lsal_conv_model u_conv (.clock(clock), .rst(rst), .conv_req(conv_req),
		.conv_rsp(conv_rsp), .mant(mant), .thr(thr), .wait_n(wait_n));

	always #5 clock = ~clock;

	task automatic tick(int n = 1);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// every access ends one idle cycle later so a strobe never rises twice at once
	task automatic wr(logic [15:0] v);
		host.wr = 1'b1;
		host.wdata = v;
		tick();
		host.wr = 1'b0;
		tick();
	endtask
	task automatic rd(int n);
		host.rd = 1'b1;
		tick(n);
		host.rd = 1'b0;
		rd_v = cfg_rdata;
		tick();
	endtask
	task automatic fin(int n);
		int t = 0;
		while (n > 0 && t < 400) begin
			tick();
			t++;
			if (conv_rsp.done === 1'b1) n--;
		end
		chk("fin", 16'(n), 16'h0);
		tick();
	endtask
	// limit compare is linear power: mantissa shifted by exponent
	function automatic logic [26:0] pw(logic [15:0] w);
		return 27'(w[11:0]) << w[15:12];
	endfunction
	function automatic logic [15:0] lim();
		logic [15:0] v;
		v = 16'($random(seed));
		v[15:12] = v[15:12] % 4'hc;
		return v;
	endfunction
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		results();
	end

	initial begin
		tick(12);
		rst = 1'b0;
		tick();
		rd(1);
		chk("reset", rd_v, 16'hc810);
		chk("pin", alert_pin, 1'b1);
		wr(16'h01f0);
		rd(1);
		chk("ro", rd_v, 16'h0010);
		foreach (tab[i]) begin
			thr = tab[i][11:8];
			wr({tab[i][15:12], 12'h210});
			fin(tab[i][7:4]);
			rd(1);
			chk("ovf", rd_v[8], thr > tab[i][3:0]);
			chk("exp", result_value[15:12], tab[i][3:0]);
		end
		thr = 4'h0;
		repeat (20) begin
			cf = 16'($random(seed));
			cf[15:12] = cf[15:12] % 4'hc;
			cf[11:4] = 8'h20;
			cf[1:0] = 2'b00;
			low_limit = lim();
			high_limit = lim();
			mant = 12'($random(seed));
			wait_n = {1'b0, 3'($random(seed))} + 4'h2;
			wr(cf);
			fin(1);
			ev = pw({cf[15:12], mant}) > pw(high_limit);
			lo = pw({cf[15:12], mant}) < pw(low_limit);
			chk("pin", alert_pin, cf[3] ? (ev | lo) : !(ev | lo));
			chk("res", result_value, {cf[2] ? 4'h0 : cf[15:12], mant});
			ex = {cf[15:11], 4'b0000, ev, lo, cf[4:0]};
			rd(1);
			chk("cfg", rd_v, ex | 16'h0080);
			rd(2);
			chk("cfg2", rd_v, ex);
		end
		low_limit = 16'h0000;
		mant = 12'h001;
		// single shots keep the count of measurements exact; free running would race the reads
		for (int k = 0; k < 4; k++) begin
			high_limit = 16'hbfff;
			wr({12'h021, 2'b00, 2'(k)});
			fin(1);
			rd(2);
			high_limit = 16'h0000;
			repeat ((1 << k) - 1) begin
				wr({12'h021, 2'b00, 2'(k)});
				fin(1);
			end
			rd(1);
			chk("early", rd_v[6], 1'b0);
			wr({12'h021, 2'b00, 2'(k)});
			fin(1);
			wr({12'h001, 2'b00, 2'(k)});
			chk("hold", alert_pin, 1'b0);
			rd(1);
			chk("late", rd_v[10:5], 6'b000110);
			chk("clear", alert_pin, 1'b1);
		end
		results();
	end
endmodule

bind lsal_status_alert lsal_assertions u_chk (.clock(clock), .rst(rst), .host(host),
	.cfg_rdata(cfg_rdata), .conv_req(conv_req), .conv_rsp(conv_rsp),
	.result_value(result_value), .alert_out(alert_out), .alert_oe(alert_oe));

`default_nettype wire
